// >>> core/aifs_pkg.sv
// Constants, register map and types for the ADC input frame sequencer.
// Assumes a byte-wide register port and a slow tick enable derived from mclk.
// Function
// - Sequencer state advances only on the slow 32768 Hz tick.
// - Each slot state begins exactly on a slow tick edge.
// - Sequencer emits mux step, filter start and reference swap phase.
// - One compute-engine pass is launched per frame.
// - Slot length is (3-2*fast)*(decimator_length+1)*(rate_halve+1) ticks.
// - Frame length is (3-2*fast) ticks plus slot length times slot count.
// - Frame length in decimator clocks is tick length times (48+102*fast).
// - Frames start at slot 0 and run through the programmed slot count.
// - Slot length scales with filter samples; length 1 means 288 cycles.
// - Remote-enabled current pairs are not routed through the multiplexer.
// - Remote samples go straight to engine memory in the frame's second half.
// - Gain boost bit 5 clear gives neutral pair gain of 1.
// - Metering formula value 5 selects sum of three phase products.
// - Reference chopping is governed by the two-bit field at bits 3:2.
package aifs_pkg;
    localparam logic [15:0] AIFS_ADDR_FRAME   = 16'h2100;
    localparam logic [15:0] AIFS_ADDR_SEL89   = 16'h2101;
    localparam logic [15:0] AIFS_ADDR_SEL67   = 16'h2102;
    localparam logic [15:0] AIFS_ADDR_SEL45   = 16'h2103;
    localparam logic [15:0] AIFS_ADDR_SEL23   = 16'h2104;
    localparam logic [15:0] AIFS_ADDR_SEL01   = 16'h2105;
    localparam logic [15:0] AIFS_ADDR_FORMULA = 16'h2106;
    localparam logic [15:0] AIFS_ADDR_FILTER  = 16'h210C;
    localparam logic [15:0] AIFS_ADDR_RATE    = 16'h2200;
    localparam logic [15:0] AIFS_ADDR_GAIN    = 16'h2704;
    localparam logic [15:0] AIFS_ADDR_REMOTE  = 16'h2709;
    localparam logic [7:0]  AIFS_REG_RESET    = 8'h00;
    localparam int AIFS_SLOTS_MAX      = 11;
    localparam int AIFS_FRAME_CNT_LSB  = 4;
    localparam int AIFS_FORMULA_LSB    = 5;
    localparam int AIFS_CHOP_LSB       = 2;
    localparam int AIFS_FIRLEN_LSB     = 1;
    localparam int AIFS_DIFF_LSB       = 4;
    localparam int AIFS_RATE_HALVE_BIT = 5;
    localparam int AIFS_FAST_BIT       = 4;
    localparam int AIFS_GAIN_BIT       = 5;
    localparam int AIFS_REMOTE_LSB     = 3;
    localparam int AIFS_DECIM_SLOW     = 48;
    localparam int AIFS_DECIM_FAST_ADD = 102;
    localparam int AIFS_SAMPLES_PER_LEN = 288;
    localparam logic [2:0] AIFS_FORMULA_THREE_PHASE = 3'h5;
    localparam int AIFS_MCLK_HZ        = 25000000;
    localparam int AIFS_TICK_HZ        = 32768;
    localparam int AIFS_TICK_DIV       = AIFS_MCLK_HZ / AIFS_TICK_HZ;
    localparam logic [1:0] AIFS_CHOP_OFF  = 2'h0;
    localparam logic [1:0] AIFS_CHOP_HIGH = 2'h1;
    localparam logic [1:0] AIFS_CHOP_LOW  = 2'h2;
    typedef enum logic [1:0] {AIFS_IDLE, AIFS_SETTLE, AIFS_SLOT} aifs_state_e;
endpackage

// >>> core/aifs_sequencer.sv
// Frame sequencer: steps the input multiplexer through programmed slots,
// starts the decimation filter, chops the reference, launches engine passes.
// Assumes the slow tick is an enable pulse divided down from mclk.
`timescale 1ns/1ps
module aifs_sequencer
    import aifs_pkg::*;
#(
    parameter int TICK_DIV = AIFS_TICK_DIV
) (
    input  wire logic        mclk,              // System clock
    input  wire logic        rstn,              // Async reset, active low
    input  wire logic [15:0] reg_addr,          // Register address
    input  wire logic [7:0]  reg_wdata,         // Write data
    input  wire logic        reg_wr,            // Write strobe
    input  wire logic        reg_rd,            // Read strobe
    output logic      [7:0]  reg_rdata,         // Read data, cycle after strobe
    output logic             slow_tick,         // Slow tick enable pulse
    output logic      [3:0]  slot_input_select, // Current mux input handle
    output logic      [3:0]  slot_index,        // Current slot number
    output logic             mux_step,          // Pulse at each slot start
    output logic             filter_start,      // Pulse starting a filter run
    output logic             reference_swap_phase, // Reference chop phase
    output logic             engine_pass_start, // Pulse launching engine pass
    output logic             remote_sample,     // Pulse: capture remote samples
    output logic      [2:0]  remote_route,      // Pairs a,b,c routed remotely
    output logic      [3:0]  pair_differential, // Diff enables n,a,b,c
    output logic      [2:0]  neutral_gain,      // Neutral pair gain code: 1, or 0 when boosted
    output logic             three_phase_sum,   // Formula sums phase products
    output logic      [2:0]  metering_formula_select, // Formula field
    output logic      [15:0] frame_decim_cycles // Frame length in decimator clocks
);
    typedef struct packed {
        logic [15:0] div;
        logic        tick;
        logic [7:0]  r_frame;
        logic [7:0]  r_s89;
        logic [7:0]  r_s67;
        logic [7:0]  r_s45;
        logic [7:0]  r_s23;
        logic [7:0]  r_s01;
        logic [7:0]  r_form;
        logic [7:0]  r_filt;
        logic [7:0]  r_rate;
        logic [7:0]  r_gain;
        logic [7:0]  r_rmt;
        logic [7:0]  rdata;
        aifs_state_e st;
        logic [7:0]  cnt;
        logic [3:0]  slot;
        logic [3:0]  nslots;
        logic [7:0]  slot_len;
        logic [3:0]  sel;
        logic        step;
        logic        fstart;
        logic        eng;
        logic        rsamp;
        logic        phase;
    } aifs_s;

    aifs_s q, d;

    function automatic logic [3:0] aifs_slot_sel(input aifs_s s, input logic [3:0] n);
        case (n)
            4'h0:    aifs_slot_sel = s.r_s01[3:0];
            4'h1:    aifs_slot_sel = s.r_s01[7:4];
            4'h2:    aifs_slot_sel = s.r_s23[3:0];
            4'h3:    aifs_slot_sel = s.r_s23[7:4];
            4'h4:    aifs_slot_sel = s.r_s45[3:0];
            4'h5:    aifs_slot_sel = s.r_s45[7:4];
            4'h6:    aifs_slot_sel = s.r_s67[3:0];
            4'h7:    aifs_slot_sel = s.r_s67[7:4];
            4'h8:    aifs_slot_sel = s.r_s89[3:0];
            4'h9:    aifs_slot_sel = s.r_s89[7:4];
            default: aifs_slot_sel = s.r_frame[3:0];
        endcase
    endfunction

    logic       fast;
    logic       halve;
    logic [1:0] firlen;
    logic [3:0] count_cfg;
    logic [1:0] base;
    logic [7:0] slot_len_cfg;
    // Nine bits: a slow frame of eleven long slots runs past 255 ticks
    logic [8:0] frame_ticks;
    logic [1:0] chop;

    always_comb begin
        fast         = q.r_rate[AIFS_FAST_BIT];
        halve        = q.r_rate[AIFS_RATE_HALVE_BIT];
        firlen       = q.r_filt[AIFS_FIRLEN_LSB +: 2];
        chop         = q.r_form[AIFS_CHOP_LSB +: 2];
        count_cfg    = q.r_frame[AIFS_FRAME_CNT_LSB +: 4];
        if (count_cfg > 4'(AIFS_SLOTS_MAX))
            count_cfg = 4'(AIFS_SLOTS_MAX);
        base         = fast ? 2'h1 : 2'h3;
        // Slot length scales with filter sample count
        slot_len_cfg = 8'(base * ({1'b0, firlen} + 3'h1) * ({1'b0, halve} + 2'h1));
        frame_ticks  = 9'(9'(base) + 9'(slot_len_cfg) * 9'(count_cfg));
    end

    always_comb begin
        d        = q;
        d.step   = 1'b0;
        d.fstart = 1'b0;
        d.eng    = 1'b0;
        d.rsamp  = 1'b0;
        d.tick   = 1'b0;
        if (q.div == 16'(TICK_DIV - 1)) begin
            d.div  = 16'h0000;
            d.tick = 1'b1;
        end else begin
            d.div = q.div + 16'h0001;
        end
        if (reg_wr) begin
            case (reg_addr)
                AIFS_ADDR_FRAME:   d.r_frame = reg_wdata;
                AIFS_ADDR_SEL89:   d.r_s89   = reg_wdata;
                AIFS_ADDR_SEL67:   d.r_s67   = reg_wdata;
                AIFS_ADDR_SEL45:   d.r_s45   = reg_wdata;
                AIFS_ADDR_SEL23:   d.r_s23   = reg_wdata;
                AIFS_ADDR_SEL01:   d.r_s01   = reg_wdata;
                AIFS_ADDR_FORMULA: d.r_form  = reg_wdata;
                AIFS_ADDR_FILTER:  d.r_filt  = reg_wdata;
                AIFS_ADDR_RATE:    d.r_rate  = reg_wdata;
                AIFS_ADDR_GAIN:    d.r_gain  = reg_wdata;
                AIFS_ADDR_REMOTE:  d.r_rmt   = reg_wdata;
                default: ;
            endcase
        end
        d.rdata = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                AIFS_ADDR_FRAME:   d.rdata = q.r_frame;
                AIFS_ADDR_SEL89:   d.rdata = q.r_s89;
                AIFS_ADDR_SEL67:   d.rdata = q.r_s67;
                AIFS_ADDR_SEL45:   d.rdata = q.r_s45;
                AIFS_ADDR_SEL23:   d.rdata = q.r_s23;
                AIFS_ADDR_SEL01:   d.rdata = q.r_s01;
                AIFS_ADDR_FORMULA: d.rdata = q.r_form;
                AIFS_ADDR_FILTER:  d.rdata = q.r_filt;
                AIFS_ADDR_RATE:    d.rdata = q.r_rate;
                AIFS_ADDR_GAIN:    d.rdata = q.r_gain;
                AIFS_ADDR_REMOTE:  d.rdata = q.r_rmt;
                default:           d.rdata = 8'h00;
            endcase
        end
        // All sequencing happens only on the slow tick
        if (q.tick) begin
            case (q.st)
                AIFS_IDLE: begin
                    // Slot count and slot length are latched at frame start; slot selections are read live at each slot start
                    if (count_cfg != 4'h0) begin
                        d.st       = AIFS_SETTLE;
                        d.cnt      = 8'(base) - 8'h01;
                        d.nslots   = count_cfg;
                        d.slot_len = slot_len_cfg;
                        d.eng      = 1'b1;
                    end
                end
                AIFS_SETTLE: begin
                    if (q.cnt == 8'h00) begin
                        d.st     = AIFS_SLOT;
                        d.slot   = 4'h0;
                        d.sel    = aifs_slot_sel(q, 4'h0);
                        d.cnt    = q.slot_len - 8'h01;
                        d.step   = 1'b1;
                        d.fstart = 1'b1;
                    end else begin
                        d.cnt = q.cnt - 8'h01;
                    end
                end
                AIFS_SLOT: begin
                    if (q.slot == (q.nslots >> 1) && q.cnt == q.slot_len - 8'h01)
                        d.rsamp = |q.r_rmt[AIFS_REMOTE_LSB +: 3];
                    if (q.cnt != 8'h00) begin
                        d.cnt = q.cnt - 8'h01;
                    end else if (q.slot + 4'h1 < q.nslots) begin
                        d.slot   = q.slot + 4'h1;
                        d.sel    = aifs_slot_sel(q, q.slot + 4'h1);
                        d.cnt    = q.slot_len - 8'h01;
                        d.step   = 1'b1;
                        d.fstart = 1'b1;
                    end else if (count_cfg != 4'h0) begin
                        // Back-to-back frame with freshly latched settings
                        d.st       = AIFS_SETTLE;
                        d.cnt      = 8'(base) - 8'h01;
                        d.nslots   = count_cfg;
                        d.slot_len = slot_len_cfg;
                        d.eng      = 1'b1;
                    end else begin
                        d.st = AIFS_IDLE;
                    end
                end
                default: d.st = AIFS_IDLE;
            endcase
        end
        // Reference swaps each slot when auto chopping; fixed levels otherwise
        case (chop)
            AIFS_CHOP_OFF:  d.phase = 1'b0;
            AIFS_CHOP_HIGH: d.phase = 1'b1;
            AIFS_CHOP_LOW:  d.phase = 1'b0;
            default:        d.phase = (d.step ? ~q.phase : q.phase);
        endcase
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            q <= '{div:      16'h0000,
                   tick:     1'b0,
                   r_frame:  AIFS_REG_RESET,
                   r_s89:    AIFS_REG_RESET,
                   r_s67:    AIFS_REG_RESET,
                   r_s45:    AIFS_REG_RESET,
                   r_s23:    AIFS_REG_RESET,
                   r_s01:    AIFS_REG_RESET,
                   r_form:   AIFS_REG_RESET,
                   r_filt:   AIFS_REG_RESET,
                   r_rate:   AIFS_REG_RESET,
                   r_gain:   AIFS_REG_RESET,
                   r_rmt:    AIFS_REG_RESET,
                   rdata:    8'h00,
                   st:       AIFS_IDLE,
                   cnt:      8'h00,
                   slot:     4'h0,
                   nslots:   4'h0,
                   slot_len: 8'h00,
                   sel:      4'h0,
                   step:     1'b0,
                   fstart:   1'b0,
                   eng:      1'b0,
                   rsamp:    1'b0,
                   phase:    1'b0};
        end else begin
            q <= d;
        end
    end

    assign reg_rdata               = q.rdata;
    assign slow_tick               = q.tick;
    assign slot_input_select       = q.sel;
    assign slot_index              = q.slot;
    assign mux_step                = q.step;
    assign filter_start            = q.fstart;
    assign reference_swap_phase    = q.phase;
    assign engine_pass_start       = q.eng;
    assign remote_sample           = q.rsamp;
    assign remote_route            = q.r_rmt[AIFS_REMOTE_LSB +: 3];
    assign pair_differential       = q.r_filt[AIFS_DIFF_LSB +: 4];
    assign neutral_gain            = q.r_gain[AIFS_GAIN_BIT] ? 3'h0 : 3'h1;
    assign metering_formula_select = q.r_form[AIFS_FORMULA_LSB +: 3];
    assign three_phase_sum         = (metering_formula_select == AIFS_FORMULA_THREE_PHASE);
    assign frame_decim_cycles      = 16'(frame_ticks * (fast ? 8'(AIFS_DECIM_SLOW + AIFS_DECIM_FAST_ADD)
                                                             : 8'(AIFS_DECIM_SLOW)));
endmodule

// >>> sim/aifs_sequencer_sva.sv
// Port checker for the frame sequencer, bound into every instance.
// Assumes one clock domain, mclk, with rstn as the asynchronous reset.
`timescale 1ns/1ps
module aifs_sequencer_sva
    import aifs_pkg::*;
#(
    parameter int TICK_DIV = AIFS_TICK_DIV
) (
    input wire logic        mclk,                    // System clock
    input wire logic        rstn,                    // Reset, active low
    input wire logic [15:0] reg_addr,                // Register address
    input wire logic [7:0]  reg_wdata,               // Write data
    input wire logic        reg_wr,                  // Write strobe
    input wire logic        slow_tick,               // Slow tick pulse
    input wire logic [3:0]  slot_index,              // Current slot
    input wire logic        mux_step,                // Slot start pulse
    input wire logic        filter_start,            // Filter start pulse
    input wire logic        engine_pass_start,       // Engine pass pulse
    input wire logic [2:0]  remote_route,            // Remote pairs
    input wire logic [2:0]  neutral_gain,            // Neutral gain code
    input wire logic        three_phase_sum,         // Formula flag
    input wire logic [2:0]  metering_formula_select  // Formula field
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);
    logic [15:0] gap;
    logic        seen;
    // The first tick after reset has no reference, so its spacing is not judged
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            gap  <= 16'h0000;
            seen <= 1'b0;
        end else if (slow_tick) begin
            gap  <= 16'h0000;
            seen <= 1'b1;
        end else begin
            gap <= gap + 16'h0001;
        end
    end
    logic       pend;
    logic [3:0] ticks_in;
    // Settle ticks are counted so the slot 0 check holds at any tick rate
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            pend     <= 1'b0;
            ticks_in <= 4'h0;
        end else if (engine_pass_start) begin
            pend     <= 1'b1;
            ticks_in <= 4'h0;
        end else if (mux_step) begin
            pend <= 1'b0;
        end else if (pend && slow_tick && ticks_in != 4'hF) begin
            ticks_in <= ticks_in + 4'h1;
        end
    end
    property p_tick_period;
        seen && slow_tick |-> gap == 16'(TICK_DIV - 1);
    endproperty
    a_tick_period: assert property (p_tick_period) else $error("slow tick spacing wrong");
    property p_step_on_tick;
        mux_step |-> $past(slow_tick);
    endproperty
    a_step_on_tick: assert property (p_step_on_tick) else $error("slot start off tick");
    property p_filter_with_step;
        mux_step == filter_start;
    endproperty
    a_filter_with_step: assert property (p_filter_with_step) else $error("filter start apart from step");
    property p_pass_on_tick;
        engine_pass_start |-> $past(slow_tick) && !filter_start;
    endproperty
    a_pass_on_tick: assert property (p_pass_on_tick) else $error("engine pass off tick");
    property p_slot0_after_pass;
        pend |-> ticks_in <= 4'h3 && (!mux_step || slot_index == 4'h0);
    endproperty
    a_slot0_after_pass: assert property (p_slot0_after_pass) else $error("frame did not open at slot 0");
    property p_three_phase;
        logic [2:0] f;
        (reg_wr && reg_addr == AIFS_ADDR_FORMULA, f = reg_wdata[7:5]) |=>
            metering_formula_select == f && three_phase_sum == (f == AIFS_FORMULA_THREE_PHASE);
    endproperty
    a_three_phase: assert property (p_three_phase) else $error("formula flag wrong");
    property p_gain_unity;
        logic b;
        (reg_wr && reg_addr == AIFS_ADDR_GAIN, b = reg_wdata[5]) |=> neutral_gain == (b ? 3'h0 : 3'h1);
    endproperty
    a_gain_unity: assert property (p_gain_unity) else $error("neutral gain wrong");
    property p_remote_route;
        logic [2:0] r;
        (reg_wr && reg_addr == AIFS_ADDR_REMOTE, r = reg_wdata[5:3]) |=> remote_route == r;
    endproperty
    a_remote_route: assert property (p_remote_route) else $error("remote routing wrong");
    c_last_slot: cover property (mux_step && slot_index == 4'h6);
    c_pass: cover property (engine_pass_start);
    c_remote: cover property (remote_route == 3'h7);
endmodule
bind aifs_sequencer aifs_sequencer_sva #(.TICK_DIV(TICK_DIV)) u_sva (.mclk(mclk), .rstn(rstn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .slow_tick(slow_tick),
    .slot_index(slot_index), .mux_step(mux_step), .filter_start(filter_start),
    .engine_pass_start(engine_pass_start), .remote_route(remote_route), .neutral_gain(neutral_gain),
    .three_phase_sum(three_phase_sum), .metering_formula_select(metering_formula_select));

// >>> sim/aifs_far_side.sv
// Converter, filter and engine seen from the sequencer: counts what is asked.
// Assumes single-cycle request pulses on mclk; it never pushes back.
`timescale 1ns/1ps
module aifs_far_side (
    input wire logic mclk,              // System clock
    input wire logic filter_start,      // Filter run request
    input wire logic engine_pass_start, // Engine pass request
    input wire logic remote_sample      // Remote capture request
);
    int convs = 0;
    int passes = 0;
    int remotes = 0;
    always @(posedge mclk) begin
        convs   <= convs + int'(filter_start);
        passes  <= passes + int'(engine_pass_start);
        remotes <= remotes + int'(remote_sample);
    end
endmodule

// >>> sim/tb_aifs_sequencer.sv
// Testbench: register port, frame timing for two setups, chop codes, idle.
// Assumes TICK_DIV of 4, so one slow tick spans four mclk cycles.
`timescale 1ns/1ps
module tb_aifs_sequencer
    import aifs_pkg::*;
;
    logic        mclk, rstn, reg_wr, reg_rd, slow_tick, mux_step, filter_start, ph, p1;
    logic        reference_swap_phase, engine_pass_start, remote_sample, three_phase_sum;
    logic [15:0] reg_addr, frame_decim_cycles;
    logic [7:0]  reg_wdata, reg_rdata;
    logic [3:0]  slot_input_select, slot_index, pair_differential;
    logic [2:0]  remote_route, neutral_gain, metering_formula_select;
    int          n_fail = 0, num_checks = 0, c;
    logic [15:0] addrs [11] = '{AIFS_ADDR_FRAME, AIFS_ADDR_SEL89, AIFS_ADDR_SEL67, AIFS_ADDR_SEL45,
        AIFS_ADDR_SEL23, AIFS_ADDR_SEL01, AIFS_ADDR_FORMULA, AIFS_ADDR_FILTER, AIFS_ADDR_RATE,
        AIFS_ADDR_GAIN, AIFS_ADDR_REMOTE};
    aifs_sequencer #(.TICK_DIV(4)) DUT (.mclk(mclk), .rstn(rstn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .slow_tick(slow_tick), .slot_input_select(slot_input_select), .slot_index(slot_index),
        .mux_step(mux_step), .filter_start(filter_start), .reference_swap_phase(reference_swap_phase),
        .engine_pass_start(engine_pass_start), .remote_sample(remote_sample),
        .remote_route(remote_route), .pair_differential(pair_differential), .neutral_gain(neutral_gain),
        .three_phase_sum(three_phase_sum), .metering_formula_select(metering_formula_select),
        .frame_decim_cycles(frame_decim_cycles));
    aifs_far_side u_far (.mclk(mclk), .filter_start(filter_start), .engine_pass_start(engine_pass_start),
        .remote_sample(remote_sample));
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Each access leaves an idle edge behind so no strobe is set twice in one step
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 chk(16'(reg_rdata), 16'(e));
        @(posedge mclk);
    endtask
    // Waits for 0 engine pass, 1 slot start, 2 remote capture; n returns cycles taken
    task automatic wait_ev(input int w, output int n);
        n = 0;
        do begin
            @(posedge mclk);
            #1 n++;
            if (n > 3000) begin
                n_fail++;
                wrap_up();
            end
        end while ((w == 0 ? engine_pass_start : (w == 1 ? mux_step : remote_sample)) !== 1'b1);
    endtask
    task automatic run(input logic [7:0] v [11], input logic [3:0] s [$], input int sc, input int fc);
        int n;
        int t;
        int c0;
        int p0;
        wr(AIFS_ADDR_FRAME, 8'h00);
        for (int i = 10; i >= 0; i--) wr(addrs[i], v[i]);
        wait_ev(0, n);
        t = 0;
        c0 = u_far.convs;
        p0 = u_far.passes;
        foreach (s[i]) begin
            wait_ev(1, n);
            t += n;
            chk(16'(slot_index), 16'(i));
            chk(16'(slot_input_select), 16'(s[i]));
            if (i > 0) chk(16'(n), 16'(sc));
        end
        ph = reference_swap_phase;
        wait_ev(0, n);
        chk(16'(t + n), 16'(fc));
        chk(16'(u_far.convs - c0), 16'(s.size()));
        chk(16'(u_far.passes - p0), 16'h0001);
    endtask
    initial begin
        rstn = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 16'h0000;
        reg_wdata = 8'h00;
        repeat (4) @(posedge mclk);
        rstn <= 1'b1;
        @(posedge mclk);
        #1 chk(16'(neutral_gain), 16'h0001);
        foreach (addrs[i]) rd(addrs[i], AIFS_REG_RESET);
        foreach (addrs[i]) wr(addrs[i], (i == 0) ? 8'h0B : 8'h5A ^ 8'(i));
        foreach (addrs[i]) rd(addrs[i], (i == 0) ? 8'h0B : 8'h5A ^ 8'(i));
        wr(16'h2107, 8'hFF);
        rd(16'h2107, 8'h00);
        run('{8'h70, 8'h00, 8'h00, 8'hA6, 8'h94, 8'h82, 8'hA0, 8'hF2, 8'h10, 8'h00, 8'h00},
            '{4'h2, 4'h8, 4'h4, 4'h9, 4'h6, 4'hA, 4'h0}, 8, 60);
        chk(frame_decim_cycles, 16'h08CA);
        chk(16'(three_phase_sum), 16'h0001);
        chk(16'(metering_formula_select), 16'h0005);
        chk(16'(pair_differential), 16'h000F);
        run('{8'h60, 8'h00, 8'h00, 8'hA9, 8'h81, 8'h10, 8'hA0, 8'h12, 8'h10, 8'h20, 8'h38},
            '{4'h0, 4'h1, 4'h1, 4'h8, 4'h9, 4'hA}, 8, 52);
        chk(frame_decim_cycles, 16'h079E);
        chk(16'(remote_route), 16'h0007);
        chk(16'(pair_differential), 16'h0001);
        chk(16'(neutral_gain), 16'h0000);
        wait_ev(2, c);
        chk(16'(slot_index), 16'h0003);
        for (int k = 0; k < 4; k++) begin
            for (int r = 0; r < 2; r++) begin
                run('{8'h10, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'(k << 2), 8'h00, 8'h20, 8'h00, 8'h00},
                    '{4'h0}, 0, 36);
            end
            // Toggle mode is judged across exactly one slot start
            if (k == 3) begin
                p1 = reference_swap_phase;
                wait_ev(1, c);
                chk(16'(reference_swap_phase ^ p1), 16'h0001);
            end else begin
                chk(16'(ph), 16'(k == 1));
            end
        end
        chk(frame_decim_cycles, 16'h01B0);
        wr(AIFS_ADDR_FRAME, 8'h00);
        repeat (40) @(posedge mclk);
        c = u_far.passes;
        repeat (200) @(posedge mclk);
        chk(16'(u_far.passes - c), 16'h0000);
        wrap_up();
    end
endmodule
